// [cilc_top.sv]
/*
 Camera I/O line conditioner top: AHB-Lite register slave, pin
 synchronisers, input routing and output source selection.
 Assumes a 250 MHz hclk, single-word AHB-Lite transfers and status
 signals from the acquisition logic on the same clock.
*/
// The placing of the registers and the AHB-Lite register port were left to the implementer.
// Summary of operation
// - Each input pin can trigger burst begin, frame begin or count clear.
// - After reset the opto input drives frame begin.
// - Filter accepts a level only after it holds for the filter time.
// - Accepted change is forwarded delayed by the filter time.
// - Each input pin has its own filter time, 0 to 20000 us.
// - Each input pin has an independent polarity flip.
// - Changing polarity flip starts exactly one frame acquisition.
// - Each output pin drives one selected internal or software source.
// - After reset the opto output takes software bit 1.
// - Integration on source is refused on variants lacking it.
// - Narrow output pulses are stretched to the minimum width, less up to one 1 us tick of counting phase.
// - Pulses at or above the minimum pass unchanged.
// - Each output pin has its own minimum width, 0 to 100 us.
// - Per-pin settings are reached through the pin select register.
`timescale 1ns/1ps
module cilc_top
#(
	parameter int  NPIN       = 4,
	parameter bit  HAS_INTEG  = 1'b1
)
(
	input  wire logic                  hclk,
	input  wire logic                  hresetn,
	input  wire logic                  hsel,
	input  wire logic [31:0]           haddr,
	input  wire logic [1:0]            htrans,
	input  wire logic                  hwrite,
	input  wire logic [2:0]            hsize,
	input  wire logic [31:0]           hwdata,
	input  wire logic                  hready,
	output logic [31:0]                hrdata,
	output logic                       hreadyout,
	output logic                       hresp,
	input  wire logic                  opto_in,
	output logic                       opto_out,
	input  wire logic                  bidir_a_i,
	output logic                       bidir_a_o,
	output logic                       bidir_a_oe,
	input  wire logic                  bidir_b_i,
	output logic                       bidir_b_o,
	output logic                       bidir_b_oe,
	input  wire cilc_pkg::cilc_status_s status,
	output cilc_pkg::cilc_trig_s       trig
);

	localparam int FW = 15;
	localparam int WW = 7;

	if (NPIN != 4 || cilc_pkg::TICK_CYCLES > 256)
	begin : g_bad_cfg
		$error("cilc_top serves four pins with an 8-bit tick divider");
	end

	logic [1:0]                 sel_ff;
	logic [FW-1:0]              filt_ff   [NPIN];
	logic [NPIN-1:0]            flip_ff;
	cilc_pkg::cilc_route_e      route_ff  [NPIN];
	cilc_pkg::cilc_src_e        src_ff    [NPIN];
	logic [WW-1:0]              width_ff  [NPIN];
	logic [NPIN-1:0]            swbit_ff;
	logic [1:0]                 dir_ff;
	logic                       auto_ff;
	logic [7:0]                 tick_cnt_ff;
	logic                       tick;
	logic [NPIN-1:0]            sync1_ff;
	logic [NPIN-1:0]            sync2_ff;
	logic [NPIN-1:0]            line_level;
	logic [NPIN-1:0]            line_edge;
	logic [NPIN-1:0]            src_level;
	logic [NPIN-1:0]            drive_level;
	logic [NPIN-1:0]            in_ok;
	logic                       dph_ff;
	logic                       dwr_ff;
	logic [7:0]                 daddr_ff;
	logic                       wr_en;
	logic [31:0]                rd_mux;

	// One microsecond tick from the system clock
	assign tick = tick_cnt_ff == 8'(cilc_pkg::TICK_CYCLES - 1);

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			tick_cnt_ff <= 8'h00;
		else
			tick_cnt_ff <= tick ? 8'h00 : tick_cnt_ff + 8'h01;
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			sync1_ff <= '0;
			sync2_ff <= '0;
		end
		else
		begin
			sync1_ff <= {bidir_b_i, bidir_a_i, 1'b0, opto_in};
			sync2_ff <= sync1_ff;
		end
	end

	// Input-capable pins: opto input and bidirectional pins set as input
	assign in_ok = {!dir_ff[1], !dir_ff[0], 1'b0, 1'b1};

	// Bus address phase capture
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			dph_ff   <= 1'b0;
			dwr_ff   <= 1'b0;
			daddr_ff <= 8'h00;
		end
		else if (hready)
		begin
			dph_ff   <= hsel && htrans[1];
			dwr_ff   <= hsel && htrans[1] && hwrite;
			daddr_ff <= haddr[7:0];
		end
	end

	assign wr_en     = dph_ff && dwr_ff;
	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;

	function automatic logic src_legal(input logic [2:0] v);
		src_legal = (v <= cilc_pkg::SRC_LAST) &&
			(HAS_INTEG || v != 3'(cilc_pkg::CILC_SRC_INTEG_ON));
	endfunction

	// Register writes; per-pin settings go to the selected pin only, software bits to all pins, direction to both bidirectional pins
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			sel_ff   <= 2'd0;
			flip_ff  <= '0;
			swbit_ff <= '0;
			dir_ff   <= 2'b00;
			auto_ff  <= 1'b0;
			for (int i = 0; i < NPIN; i++)
			begin
				filt_ff[i]  <= cilc_pkg::FILT_RST;
				width_ff[i] <= cilc_pkg::WIDTH_RST;
				route_ff[i] <= cilc_pkg::CILC_RT_NONE;
				src_ff[i]   <= cilc_pkg::CILC_SRC_SW_BIT;
			end
			route_ff[cilc_pkg::PIN_OPTO_IN] <= cilc_pkg::CILC_RT_FRAME;
		end
		else
		begin
			auto_ff <= 1'b0;
			if (wr_en)
			begin
				if (daddr_ff == cilc_pkg::OFS_PIN_SELECT)
					sel_ff <= hwdata[1:0];
				else if (daddr_ff == cilc_pkg::OFS_FILTER_TIME)
				begin
					if (hwdata[31:0] <= 32'(cilc_pkg::FILT_MAX_US))
						filt_ff[sel_ff] <= hwdata[FW-1:0];
				end
				else if (daddr_ff == cilc_pkg::OFS_POLARITY)
				begin
					flip_ff[sel_ff] <= hwdata[0];
					if (hwdata[0] != flip_ff[sel_ff])
						auto_ff <= 1'b1;
				end
				else if (daddr_ff == cilc_pkg::OFS_IN_ROUTE)
					route_ff[sel_ff] <= cilc_pkg::cilc_route_e'(hwdata[1:0]);
				else if (daddr_ff == cilc_pkg::OFS_OUT_SOURCE)
				begin
					if (src_legal(hwdata[2:0]))
						src_ff[sel_ff] <= cilc_pkg::cilc_src_e'(hwdata[2:0]);
				end
				else if (daddr_ff == cilc_pkg::OFS_MIN_WIDTH)
				begin
					if (hwdata[31:0] <= 32'(cilc_pkg::WIDTH_MAX_US))
						width_ff[sel_ff] <= hwdata[WW-1:0];
				end
				else if (daddr_ff == cilc_pkg::OFS_SW_OUT)
					swbit_ff <= hwdata[NPIN-1:0];
				else if (daddr_ff == cilc_pkg::OFS_DIR)
					dir_ff <= hwdata[1:0];
			end
		end
	end

	// Read mux for the selected pin
	always_comb
	begin
		rd_mux = 32'h0000_0000;
		if (daddr_ff == cilc_pkg::OFS_PIN_SELECT)
			rd_mux[1:0] = sel_ff;
		else if (daddr_ff == cilc_pkg::OFS_FILTER_TIME)
			rd_mux[FW-1:0] = filt_ff[sel_ff];
		else if (daddr_ff == cilc_pkg::OFS_POLARITY)
			rd_mux[0] = flip_ff[sel_ff];
		else if (daddr_ff == cilc_pkg::OFS_IN_ROUTE)
			rd_mux[1:0] = route_ff[sel_ff];
		else if (daddr_ff == cilc_pkg::OFS_OUT_SOURCE)
			rd_mux[2:0] = src_ff[sel_ff];
		else if (daddr_ff == cilc_pkg::OFS_MIN_WIDTH)
			rd_mux[WW-1:0] = width_ff[sel_ff];
		else if (daddr_ff == cilc_pkg::OFS_SW_OUT)
			rd_mux[NPIN-1:0] = swbit_ff;
		else if (daddr_ff == cilc_pkg::OFS_DIR)
			rd_mux[1:0] = dir_ff;
		else if (daddr_ff == cilc_pkg::OFS_LINE_STATUS)
			rd_mux[NPIN-1:0] = line_level;
	end

	assign hrdata = dph_ff ? rd_mux : 32'h0000_0000;

	genvar g;
	generate
		for (g = 0; g < NPIN; g++)
		begin : g_pin
			always_comb
			begin
				case (src_ff[g])
					cilc_pkg::CILC_SRC_BURST_WAIT: src_level[g] = status.burst_wait;
					cilc_pkg::CILC_SRC_FRAME_WAIT: src_level[g] = status.frame_wait;
					cilc_pkg::CILC_SRC_INTEG_ON:   src_level[g] = status.integ_on;
					cilc_pkg::CILC_SRC_ILLUM_WIN:  src_level[g] = status.illum_win;
					cilc_pkg::CILC_SRC_DELAY_PULS: src_level[g] = status.delay_pulse;
					default:                       src_level[g] = swbit_ff[g];
				endcase
			end

			cilc_pin_cond #(.FW(FW), .WW(WW)) u_cond
			(
				.hclk        (hclk),
				.hresetn     (hresetn),
				.tick        (tick),
				.pin_raw     (sync2_ff[g]),
				.filt_time   (filt_ff[g]),
				.flip        (flip_ff[g]),
				.line_level  (line_level[g]),
				.line_edge   (line_edge[g]),
				.src_level   (src_level[g]),
				.min_width   (width_ff[g]),
				.drive_level (drive_level[g])
			);

			a_src_legal : assert property (@(posedge hclk) disable iff (!hresetn)
				(src_ff[g] <= cilc_pkg::SRC_LAST) &&
				(HAS_INTEG || src_ff[g] != cilc_pkg::CILC_SRC_INTEG_ON))
				else $error("illegal output source held");
		end
	endgenerate

	// Trigger routing from accepted edges
	function automatic logic route_hit(input cilc_pkg::cilc_route_e want,
		input logic [NPIN-1:0] edg, input logic [NPIN-1:0] ok,
		input cilc_pkg::cilc_route_e r0, input cilc_pkg::cilc_route_e r2,
		input cilc_pkg::cilc_route_e r3);
		route_hit = (edg[0] && ok[0] && r0 == want) ||
			(edg[2] && ok[2] && r2 == want) ||
			(edg[3] && ok[3] && r3 == want);
	endfunction

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			trig <= '0;
		else
		begin
			trig.burst_begin <= route_hit(cilc_pkg::CILC_RT_BURST, line_edge, in_ok,
				route_ff[0], route_ff[2], route_ff[3]);
			trig.frame_begin <= route_hit(cilc_pkg::CILC_RT_FRAME, line_edge, in_ok,
				route_ff[0], route_ff[2], route_ff[3]);
			trig.count_clear <= route_hit(cilc_pkg::CILC_RT_CLEAR, line_edge, in_ok,
				route_ff[0], route_ff[2], route_ff[3]);
			trig.auto_frame  <= auto_ff;
		end
	end

	assign opto_out   = drive_level[cilc_pkg::PIN_OPTO_OUT];
	assign bidir_a_o  = drive_level[cilc_pkg::PIN_BIDIR_A];
	assign bidir_a_oe = dir_ff[0];
	assign bidir_b_o  = drive_level[cilc_pkg::PIN_BIDIR_B];
	assign bidir_b_oe = dir_ff[1];

	a_auto_one_pulse : assert property (@(posedge hclk) disable iff (!hresetn)
		trig.auto_frame |=> !trig.auto_frame) else $error("auto frame not single");
	a_flip_starts : assert property (@(posedge hclk) disable iff (!hresetn)
		$changed(flip_ff) |=> trig.auto_frame) else $error("flip change without frame");
	a_integ_refused : assert property (@(posedge hclk) disable iff (!hresetn)
		!HAS_INTEG |-> src_ff[1] != cilc_pkg::CILC_SRC_INTEG_ON) else $error("integ source");
	a_filt_range : assert property (@(posedge hclk) disable iff (!hresetn)
		filt_ff[0] <= 15'(cilc_pkg::FILT_MAX_US)) else $error("filter time out of range");
	a_width_range : assert property (@(posedge hclk) disable iff (!hresetn)
		width_ff[1] <= 7'(cilc_pkg::WIDTH_MAX_US)) else $error("width out of range");
	a_frame_route : assert property (@(posedge hclk) disable iff (!hresetn)
		(line_edge[0] && route_ff[0] == cilc_pkg::CILC_RT_FRAME) |=> trig.frame_begin)
		else $error("frame trigger missed");
	a_tick_single : assert property (@(posedge hclk) disable iff (!hresetn)
		tick |=> !tick) else $error("tick longer than one cycle");
	a_burst_route : assert property (@(posedge hclk) disable iff (!hresetn)
		(line_edge[2] && in_ok[2] && route_ff[2] == cilc_pkg::CILC_RT_BURST)
		|=> trig.burst_begin) else $error("burst trigger missed");
	a_clear_route : assert property (@(posedge hclk) disable iff (!hresetn)
		(line_edge[3] && in_ok[3] && route_ff[3] == cilc_pkg::CILC_RT_CLEAR)
		|=> trig.count_clear) else $error("count clear missed");
	a_frame_pin_b : assert property (@(posedge hclk) disable iff (!hresetn)
		(line_edge[3] && in_ok[3] && route_ff[3] == cilc_pkg::CILC_RT_FRAME)
		|=> trig.frame_begin) else $error("frame trigger from pin b missed");
	a_burst_opto : assert property (@(posedge hclk) disable iff (!hresetn)
		(line_edge[0] && route_ff[0] == cilc_pkg::CILC_RT_BURST)
		|=> trig.burst_begin) else $error("burst trigger from opto input missed");
	a_out_quiet : assert property (@(posedge hclk) disable iff (!hresetn)
		(dir_ff == 2'b11 && route_ff[0] != cilc_pkg::CILC_RT_BURST)
		|=> !trig.burst_begin) else $error("output pin raised a trigger");
	a_out_rise : assert property (@(posedge hclk) disable iff (!hresetn)
		(width_ff[1] == '0 && src_level[1])
		|=> opto_out) else $error("opto output not following source high");
	a_out_fall : assert property (@(posedge hclk) disable iff (!hresetn)
		(width_ff[1] == '0 && !src_level[1])
		|=> !opto_out) else $error("opto output not following source low");
	a_filt_hold : assert property (@(posedge hclk) disable iff (!hresetn)
		(wr_en && daddr_ff == cilc_pkg::OFS_FILTER_TIME && sel_ff != cilc_pkg::PIN_OPTO_IN)
		|=> $stable(filt_ff[0])) else $error("unselected filter time changed");
	a_width_hold : assert property (@(posedge hclk) disable iff (!hresetn)
		(wr_en && daddr_ff == cilc_pkg::OFS_MIN_WIDTH && sel_ff != cilc_pkg::PIN_OPTO_OUT)
		|=> $stable(width_ff[1])) else $error("unselected width changed");
	a_sel_write : assert property (@(posedge hclk) disable iff (!hresetn)
		(wr_en && daddr_ff == cilc_pkg::OFS_PIN_SELECT)
		|=> sel_ff == $past(hwdata[1:0])) else $error("pin select not written");
	a_auto_cause : assert property (@(posedge hclk) disable iff (!hresetn)
		trig.auto_frame
		|-> $past(flip_ff, 2) != $past(flip_ff)) else $error("auto frame without flip change");
	c_frame_trig : cover property (@(posedge hclk) disable iff (!hresetn) trig.frame_begin);
	c_burst_trig : cover property (@(posedge hclk) disable iff (!hresetn) trig.burst_begin);
	c_auto_frame : cover property (@(posedge hclk) disable iff (!hresetn) trig.auto_frame);
	c_clear_trig : cover property (@(posedge hclk) disable iff (!hresetn) trig.count_clear);

endmodule

// [cilc_pkg.sv]
/*
 Package for the camera I/O line conditioner: register offsets, field
 positions, reset values, encodings and timing constants.
 Assumes a 250 MHz system clock and a 32-bit AHB-Lite register bus.
*/
package cilc_pkg;

	localparam int CLK_MHZ          = 250;
	localparam int TICK_US          = 1;
	localparam int TICK_CYCLES      = CLK_MHZ * TICK_US;
	localparam int FILT_MAX_US      = 20000;
	localparam int WIDTH_MAX_US     = 100;

	// Register byte offsets
	localparam logic [7:0] OFS_PIN_SELECT   = 8'h00;
	localparam logic [7:0] OFS_FILTER_TIME  = 8'h04;
	localparam logic [7:0] OFS_POLARITY     = 8'h08;
	localparam logic [7:0] OFS_IN_ROUTE     = 8'h0C;
	localparam logic [7:0] OFS_OUT_SOURCE   = 8'h10;
	localparam logic [7:0] OFS_MIN_WIDTH    = 8'h14;
	localparam logic [7:0] OFS_SW_OUT       = 8'h18;
	localparam logic [7:0] OFS_DIR          = 8'h1C;
	localparam logic [7:0] OFS_LINE_STATUS  = 8'h20;

	// Pin indices
	localparam logic [1:0] PIN_OPTO_IN  = 2'd0;
	localparam logic [1:0] PIN_OPTO_OUT = 2'd1;
	localparam logic [1:0] PIN_BIDIR_A  = 2'd2;
	localparam logic [1:0] PIN_BIDIR_B  = 2'd3;

	// Input routing targets
	typedef enum logic [1:0]
	{
		CILC_RT_NONE  = 2'd0,
		CILC_RT_BURST = 2'd1,
		CILC_RT_FRAME = 2'd2,
		CILC_RT_CLEAR = 2'd3
	} cilc_route_e;

	// Output sources
	typedef enum logic [2:0]
	{
		CILC_SRC_BURST_WAIT = 3'd0,
		CILC_SRC_FRAME_WAIT = 3'd1,
		CILC_SRC_INTEG_ON   = 3'd2,
		CILC_SRC_ILLUM_WIN  = 3'd3,
		CILC_SRC_DELAY_PULS = 3'd4,
		CILC_SRC_SW_BIT     = 3'd5
	} cilc_src_e;

	localparam logic [2:0] SRC_LAST = 3'd5;

	// Internal status signals used as output sources
	typedef struct packed
	{
		logic burst_wait;
		logic frame_wait;
		logic integ_on;
		logic illum_win;
		logic delay_pulse;
	} cilc_status_s;

	// Trigger pulses towards internal functions
	typedef struct packed
	{
		logic burst_begin;
		logic frame_begin;
		logic count_clear;
		logic auto_frame;
	} cilc_trig_s;

	localparam logic [14:0] FILT_RST  = 15'h0000;
	localparam logic [6:0]  WIDTH_RST = 7'h00;

endpackage

// [cilc_pin_cond.sv]
/*
 Per-pin conditioner: glitch filter with polarity flip on the input
 path, minimum width stretcher on the output path.
 Assumes pin_raw is already synchronised and tick is a one-cycle pulse
 once per microsecond.
*/
`timescale 1ns/1ps
module cilc_pin_cond
#(
	parameter int FW = 15,
	parameter int WW = 7
)
(
	input  wire logic          hclk,
	input  wire logic          hresetn,
	input  wire logic          tick,
	input  wire logic          pin_raw,
	input  wire logic [FW-1:0] filt_time,
	input  wire logic          flip,
	output logic               line_level,
	output logic               line_edge,
	input  wire logic          src_level,
	input  wire logic [WW-1:0] min_width,
	output logic               drive_level
);

	if ((2 ** FW) <= cilc_pkg::FILT_MAX_US || (2 ** WW) <= cilc_pkg::WIDTH_MAX_US)
	begin : g_bad_width
		$error("cilc_pin_cond counters too narrow for the setting ranges");
	end

	logic          last_raw_ff;
	logic          stable_ff;
	logic [FW-1:0] fcnt_ff;
	logic          level_ff;
	logic          src_prev_ff;
	logic [WW-1:0] wcnt_ff;
	logic          drive_ff;
	logic          raw_chg;
	logic          filt_done;
	logic          nxt_level;
	logic          src_rise;
	logic          src_fall;

	assign raw_chg   = pin_raw != last_raw_ff;
	assign filt_done = (fcnt_ff >= filt_time) && !raw_chg;
	// Accepted level only after holding for filter time
	assign nxt_level = (filt_done && (pin_raw != stable_ff)) ? pin_raw : stable_ff;
	assign src_rise  = src_level && !src_prev_ff;
	assign src_fall  = !src_level && src_prev_ff;

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			last_raw_ff <= 1'b0;
			stable_ff   <= 1'b0;
			fcnt_ff     <= '0;
			level_ff    <= 1'b0;
		end
		else
		begin
			last_raw_ff <= pin_raw;
			stable_ff   <= nxt_level;
			// Restart count on every raw transition
			if (raw_chg)
				fcnt_ff <= '0;
			else if (tick && fcnt_ff < filt_time)
				fcnt_ff <= fcnt_ff + 1'b1;
			level_ff <= nxt_level ^ flip;
		end
	end

	assign line_level = level_ff;
	assign line_edge  = (nxt_level ^ flip) != level_ff;

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			src_prev_ff <= 1'b0;
			wcnt_ff     <= '0;
			drive_ff    <= 1'b0;
		end
		else
		begin
			src_prev_ff <= src_level;
			if (src_rise)
			begin
				drive_ff <= 1'b1;
				wcnt_ff  <= '0;
			end
			else if (drive_ff && tick && wcnt_ff < min_width)
				wcnt_ff <= wcnt_ff + 1'b1;
			// Hold high until minimum reached, else follow source
			if (!src_level && drive_ff && !src_rise)
			begin
				if (wcnt_ff >= min_width || (tick && wcnt_ff + 1'b1 >= min_width))
					drive_ff <= 1'b0;
			end
		end
	end

	assign drive_level = drive_ff;

	a_drive_follows_rise : assert property (@(posedge hclk) disable iff (!hresetn)
		src_rise |=> drive_level) else $error("output did not start on source rise");
	a_zero_no_stretch : assert property (@(posedge hclk) disable iff (!hresetn)
		(min_width == '0 && src_fall) |=> !drive_level) else $error("zero width stretched");
	c_stretch : cover property (@(posedge hclk) disable iff (!hresetn)
		drive_level && !src_level);

endmodule

// [cilc_far_side.sv]
/*
 Far-side model: trigger sources on the input pins, a receiver that
 measures high pulses on the opto output.
 Assumes set_pin is called just after a rising hclk edge.
*/
`timescale 1ns/1ps
module cilc_far_side
(
	input  wire logic hclk,
	input  wire logic opto_out,
	input  wire logic bidir_a_o,
	input  wire logic bidir_a_oe,
	input  wire logic bidir_b_o,
	input  wire logic bidir_b_oe,
	output logic      opto_in,
	output logic      bidir_a_i,
	output logic      bidir_b_i
);
	logic [2:0] drv_ff     = 3'b000;
	int         run_ff     = 0;
	int         last_width = 0;
	// The design owns a shared pin while its enable is high
	assign opto_in   = drv_ff[0];
	assign bidir_a_i = bidir_a_oe ? bidir_a_o : drv_ff[1];
	assign bidir_b_i = bidir_b_oe ? bidir_b_o : drv_ff[2];
	task set_pin(input int idx, input logic v);
		drv_ff[idx] <= v;
	endtask
	always @(posedge hclk)
	begin
		if (opto_out === 1'b1)
			run_ff <= run_ff + 1;
		else
		begin
			if (run_ff != 0)
				last_width <= run_ff;
			run_ff <= 0;
		end
	end
endmodule

// [camera_io_line_conditioner_bench.sv]
/*
 Self-checking bench for the line conditioner: AHB-Lite register
 traffic, input filtering and routing, output sources and stretching.
 Assumes zero-wait slave answers and a 1 us tick of 250 hclk cycles.
*/
`timescale 1ns/1ps
module camera_io_line_conditioner_bench;
	logic                   hclk = 1'b0;
	logic                   hresetn = 1'b0;
	logic                   hsel = 1'b0;
	logic [31:0]            haddr = 32'h0000_0000;
	logic [1:0]             htrans = 2'b00;
	logic                   hwrite = 1'b0;
	logic [2:0]             hsize = 3'b010;
	logic [31:0]            hwdata = 32'h0000_0000;
	logic [31:0]            hrdata;
	logic                   hready;
	logic                   hresp;
	logic                   opto_in, opto_out, a_i, a_o, a_oe, b_i, b_o, b_oe;
	cilc_pkg::cilc_status_s status = '0;
	cilc_pkg::cilc_trig_s   trig;
	int                     n_mismatch = 0;
	int                     comparisons = 0;
	int                     cyc = 0;
	int                     t_frame = 0;
	int                     t0, p;
	int                     cnt[4] = '{default: 0};
	int                     snap[4];
	logic [31:0]            fexp[4];
	logic [31:0]            rnd = 32'h3614_ce8d;
	logic [31:0]            q;

	cilc_top #(.NPIN(4), .HAS_INTEG(1'b1)) i_dut (.hclk(hclk), .hresetn(hresetn),
		.hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
		.hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hready),
		.hresp(hresp), .opto_in(opto_in), .opto_out(opto_out), .bidir_a_i(a_i),
		.bidir_a_o(a_o), .bidir_a_oe(a_oe), .bidir_b_i(b_i), .bidir_b_o(b_o),
		.bidir_b_oe(b_oe), .status(status), .trig(trig));
	cilc_far_side far (.hclk(hclk), .opto_out(opto_out), .bidir_a_o(a_o),
		.bidir_a_oe(a_oe), .bidir_b_o(b_o), .bidir_b_oe(b_oe), .opto_in(opto_in),
		.bidir_a_i(a_i), .bidir_b_i(b_i));

	always #2 hclk = ~hclk;

	always @(posedge hclk)
	begin
		cyc <= cyc + 1;
		if (trig.burst_begin === 1'b1) cnt[0] <= cnt[0] + 1;
		if (trig.frame_begin === 1'b1) cnt[1] <= cnt[1] + 1;
		if (trig.frame_begin === 1'b1) t_frame <= cyc;
		if (trig.count_clear === 1'b1) cnt[2] <= cnt[2] + 1;
		if (trig.auto_frame === 1'b1) cnt[3] <= cnt[3] + 1;
	end

	function automatic logic [31:0] lfsr(input logic [31:0] x);
		return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
	endfunction

	task wrap_up;
		if (n_mismatch == 0 && comparisons > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp)
		begin
			n_mismatch++;
			$display("ERROR %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task chk_rng(input string nm, input int v, input int lo, input int hi);
		chk(nm, {31'h0, (v >= lo && v <= hi)}, 32'h0000_0001);
	endtask

	task wait_rdy;
		int n;
		n = 0;
		do
		begin
			@(posedge hclk);
			n++;
		end
		while (hready !== 1'b1 && n < 64);
		if (n >= 64)
		begin
			n_mismatch++;
			wrap_up();
		end
	endtask

	task bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
		hsel <= 1'b1;
		haddr <= {24'h00_0000, a};
		htrans <= 2'b10;
		hwrite <= wr;
		wait_rdy();
		htrans <= 2'b00;
		hwdata <= d;
		wait_rdy();
		q = hrdata;
		chk("hresp", {31'h0, hresp}, 32'h0000_0000);
	endtask

	task wr(input logic [7:0] a, input logic [31:0] d);
		bus(1'b1, a, d);
	endtask

	task rd(input logic [7:0] a);
		bus(1'b0, a, 32'h0000_0000);
	endtask

	task sel(input logic [1:0] pin);
		wr(cilc_pkg::OFS_PIN_SELECT, {30'h0, pin});
	endtask

	task settle(input int n);
		repeat (n) @(posedge hclk);
	endtask

	initial
	begin
		settle(60000);
		n_mismatch++;
		wrap_up();
	end

	initial
	begin
		settle(12);
		hresetn <= 1'b1;
		settle(1);
		sel(cilc_pkg::PIN_OPTO_IN);
		rd(cilc_pkg::OFS_FILTER_TIME); chk("filter_rst", q, 32'h0000_0000);
		rd(cilc_pkg::OFS_POLARITY); chk("flip_rst", q, 32'h0000_0000);
		rd(cilc_pkg::OFS_IN_ROUTE); chk("route_rst", q, {30'h0, cilc_pkg::CILC_RT_FRAME});
		sel(cilc_pkg::PIN_OPTO_OUT);
		rd(cilc_pkg::OFS_OUT_SOURCE); chk("src_rst", q, {29'h0, cilc_pkg::CILC_SRC_SW_BIT});
		rd(cilc_pkg::OFS_MIN_WIDTH); chk("width_rst", q, 32'h0000_0000);
		wr(cilc_pkg::OFS_SW_OUT, 32'h0000_0002);
		settle(3); chk("sw_bit1", {31'h0, opto_out}, 32'h0000_0001);
		rd(8'h40); chk("unmapped", q, 32'h0000_0000);
		// Every status source with random levels on all status lines
		for (int k = 0; k < 5; k++)
		begin
			wr(cilc_pkg::OFS_OUT_SOURCE, k);
			for (int j = 0; j < 4; j++)
			begin
				rnd = lfsr(rnd);
				status <= cilc_pkg::cilc_status_s'(rnd[4:0]);
				settle(3); chk("source", {31'h0, opto_out}, {31'h0, rnd[4 - k]});
			end
		end
		status <= '0;
		wr(cilc_pkg::OFS_OUT_SOURCE, {29'h0, cilc_pkg::CILC_SRC_DELAY_PULS});
		wr(cilc_pkg::OFS_MIN_WIDTH, 32'h0000_0004);
		settle(300);
		status.delay_pulse <= 1'b1; settle(10); status.delay_pulse <= 1'b0;
		settle(1300); chk_rng("stretched", far.last_width, 750, 1002);
		status.delay_pulse <= 1'b1; settle(1500); status.delay_pulse <= 1'b0;
		settle(20); chk_rng("unchanged", far.last_width, 1499, 1501);
		wr(cilc_pkg::OFS_MIN_WIDTH, 32'h0000_0065);
		rd(cilc_pkg::OFS_MIN_WIDTH); chk("width_101", q, 32'h0000_0004);
		wr(cilc_pkg::OFS_MIN_WIDTH, 32'h0000_0064);
		rd(cilc_pkg::OFS_MIN_WIDTH); chk("width_100", q, 32'h0000_0064);
		wr(cilc_pkg::OFS_OUT_SOURCE, 32'h0000_0007);
		rd(cilc_pkg::OFS_OUT_SOURCE);
		chk("src_bad", q, {29'h0, cilc_pkg::CILC_SRC_DELAY_PULS});
		// Random filter times, each input pin holds its own
		for (int i = 0; i < 6; i++)
		begin
			rnd = lfsr(rnd);
			p = (i % 3 == 0) ? 0 : i % 3 + 1;
			sel(p[1:0]);
			fexp[p] = rnd % 32'd20001;
			wr(cilc_pkg::OFS_FILTER_TIME, fexp[p]);
		end
		for (int i = 0; i < 4; i++)
		begin
			if (i == 1) continue;
			sel(i[1:0]);
			rd(cilc_pkg::OFS_FILTER_TIME); chk("filter_pin", q, fexp[i]);
		end
		wr(cilc_pkg::OFS_FILTER_TIME, 32'h0000_4E21);
		rd(cilc_pkg::OFS_FILTER_TIME); chk("filter_over", q, fexp[3]);
		wr(cilc_pkg::OFS_FILTER_TIME, 32'h0000_4E20);
		rd(cilc_pkg::OFS_FILTER_TIME); chk("filter_max", q, 32'h0000_4E20);
		// Filter of 4 us, longer than the 1 us glitch that follows
		sel(cilc_pkg::PIN_OPTO_IN);
		wr(cilc_pkg::OFS_FILTER_TIME, 32'h0000_0004);
		settle(1300);
		snap = cnt;
		far.set_pin(0, 1'b1); settle(250); far.set_pin(0, 1'b0);
		settle(1500); chk("glitch", cnt[1], snap[1]);
		far.set_pin(0, 1'b1);
		t0 = cyc;
		for (int n = 0; n < 1400 && cnt[1] == snap[1]; n++)
			settle(1);
		chk_rng("filter_delay", t_frame - t0, 750, 1258);
		far.set_pin(0, 1'b0);
		settle(1400);
		// Each routing target from bidirectional pin A
		sel(cilc_pkg::PIN_BIDIR_A);
		wr(cilc_pkg::OFS_FILTER_TIME, 32'h0000_0000);
		for (int k = 1; k < 4; k++)
		begin
			wr(cilc_pkg::OFS_IN_ROUTE, k);
			settle(300);
			snap = cnt;
			far.set_pin(1, 1'b1);
			settle(300);
			for (int j = 0; j < 3; j++)
				chk("route", cnt[j], snap[j] + (j == k - 1));
			far.set_pin(1, 1'b0);
			settle(300);
		end
		wr(cilc_pkg::OFS_IN_ROUTE, {30'h0, cilc_pkg::CILC_RT_NONE});
		snap = cnt;
		wr(cilc_pkg::OFS_POLARITY, 32'h0000_0001);
		settle(300); chk("auto_on", cnt[3], snap[3] + 1);
		rd(cilc_pkg::OFS_LINE_STATUS); chk("flip_lvl", {31'h0, q[2]}, 32'h0000_0001);
		wr(cilc_pkg::OFS_POLARITY, 32'h0000_0001);
		settle(10); chk("auto_same", cnt[3], snap[3] + 1);
		wr(cilc_pkg::OFS_POLARITY, 32'h0000_0000);
		settle(300); chk("auto_off", cnt[3], snap[3] + 2);
		rd(cilc_pkg::OFS_LINE_STATUS); chk("plain_lvl", {31'h0, q[2]}, 32'h0000_0000);
		wr(cilc_pkg::OFS_DIR, 32'h0000_0003);
		settle(2);
		chk("dir", {30'h0, b_oe, a_oe}, 32'h0000_0003);
		wr(cilc_pkg::OFS_SW_OUT, 32'h0000_0008);
		settle(3);
		chk("bidir_a_out", {31'h0, a_o}, 32'h0000_0000);
		chk("bidir_b_out", {31'h0, b_o}, 32'h0000_0001);
		wrap_up();
	end
endmodule
